/* File: dv/tb.sv */
// Self-checking testbench of the timer counter trio
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import tct_pkg::*;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  tct_pins_s   pins;
  tct_ack_s    ack = 4'h0;
  tct_irq_s    irq;
  int          failures = 0;
  int          n_tests = 0;
  logic [31:0] rd;
  logic        er;
  // 50 MHz clock
  always #10 pclk = ~pclk;
  // Design and pin model
  tct_top i_tct_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .ack(ack), .irq(irq));
  tct_pin_model i_tct_pin_model (.pclk(pclk), .pins(pins));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask
  // One APB transfer; read data lands in rd, error in er
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1, "no pready");
  endtask
  // Wait for a request bit under a bound
  task automatic wait_irq(input int b, input int lim);
    int n;
    n = 0;
    while (irq[b] !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, irq[b]}, 32'h1, "request not raised");
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  // Reset values and an unmapped read
  task automatic t_reset();
    apb(1'b0, OFS_CTRL01, 8'h00);
    chk(rd, 32'h0, "control reset");
    apb(1'b0, OFS_T2MODE, 8'h00);
    chk(rd, 32'h0, "mode reset");
    apb(1'b0, 8'h34, 8'h00);
    chk({rd[30:0], er}, 32'h1, "unmapped read");
  endtask
  // Timer 0 wrap or reload, then acknowledge
  task automatic t_t0(input logic [7:0] md, lo, hi, elo, ehi);
    apb(1'b1, OFS_MODE01, md);
    apb(1'b1, OFS_LOW0, lo);
    apb(1'b1, OFS_HIGH0, hi);
    apb(1'b1, OFS_CTRL01, 8'h10);
    wait_irq(6, 200);
    apb(1'b0, OFS_LOW0, 8'h00);
    chk(rd, {24'h0, elo}, "low byte after overflow");
    apb(1'b0, OFS_HIGH0, 8'h00);
    chk(rd, {24'h0, ehi}, "high byte after overflow");
    ack <= 4'h8;
    @(posedge pclk);
    ack <= 4'h0;
    @(posedge pclk);
    chk({31'h0, irq.timer0}, 32'h0, "flag kept after ack");
    apb(1'b1, OFS_CTRL01, 8'h00);
  endtask
  // Gate pin holds then releases the count
  task automatic t_gate();
    i_tct_pin_model.set_pin(2, 1'b0, 2);
    apb(1'b1, OFS_MODE01, 8'h09);
    apb(1'b1, OFS_LOW0, 8'h00);
    apb(1'b1, OFS_CTRL01, 8'h10);
    repeat (40) @(posedge pclk);
    apb(1'b0, OFS_LOW0, 8'h00);
    chk(rd, 32'h0, "gated count moved");
    chk({31'h0, irq.ext0}, 32'h1, "low level flag missing");
    i_tct_pin_model.set_pin(2, 1'b1, 40);
    apb(1'b0, OFS_LOW0, 8'h00);
    chk({31'h0, rd != 32'h0}, 32'h1, "open gate did not count");
    apb(1'b1, OFS_CTRL01, 8'h00);
  endtask
  // Timer 0 split: high half run by timer 1 control
  task automatic t_split();
    logic [31:0] rl;
    apb(1'b1, OFS_LOW1, 8'h1F);
    apb(1'b1, OFS_HIGH1, 8'hFF);
    apb(1'b1, OFS_MODE01, 8'h03);
    apb(1'b1, OFS_LOW0, 8'h00);
    apb(1'b1, OFS_HIGH0, 8'hFE);
    apb(1'b1, OFS_CTRL01, 8'h40);
    wait_irq(5, 200);
    apb(1'b0, OFS_CTRL01, 8'h00);
    chk(rd, 32'hC0, "split flags");
    apb(1'b0, OFS_LOW0, 8'h00);
    chk(rd, 32'h0, "stopped low half moved");
    apb(1'b1, OFS_MODE01, 8'h33);
    apb(1'b0, OFS_LOW1, 8'h00);
    rl = rd;
    repeat (20) @(posedge pclk);
    apb(1'b0, OFS_LOW1, 8'h00);
    chk(rd, rl, "timer 1 mode 3 moved");
    apb(1'b1, OFS_CTRL01, 8'h00);
    apb(1'b1, OFS_MODE01, 8'h00);
  endtask
  // Capture on trigger fall, count keeps going
  task automatic t_capture();
    logic [31:0] rl;
    apb(1'b1, OFS_LOW2, 8'h00);
    apb(1'b1, OFS_HIGH2, 8'h00);
    apb(1'b1, OFS_T2CTRL, 8'h09);
    apb(1'b1, OFS_T2CTRL, 8'h0D);
    repeat (20) @(posedge pclk);
    i_tct_pin_model.set_pin(0, 1'b0, 30);
    wait_irq(4, 50);
    apb(1'b0, OFS_T2CTRL, 8'h00);
    chk(rd, 32'h4D, "capture flags");
    apb(1'b0, OFS_RCAPL, 8'h00);
    rl = rd;
    apb(1'b0, OFS_LOW2, 8'h00);
    chk({31'h0, rl != 32'h0 && rd > rl}, 32'h1, "capture or count wrong");
    apb(1'b1, OFS_T2CTRL, 8'h00);
    i_tct_pin_model.set_pin(0, 1'b1, 2);
  endtask
  // Up count overflow reloads from the capture registers
  task automatic t_reload();
    apb(1'b1, OFS_RCAPL, 8'hF0);
    apb(1'b1, OFS_RCAPH, 8'hFF);
    apb(1'b1, OFS_LOW2, 8'hFE);
    apb(1'b1, OFS_HIGH2, 8'hFF);
    apb(1'b1, OFS_T2CTRL, 8'h04);
    wait_irq(4, 200);
    apb(1'b0, OFS_LOW2, 8'h00);
    chk(rd, 32'hF0, "reload value");
    apb(1'b1, OFS_T2CTRL, 8'h00);
  endtask
  // Down count to the reload value, then all ones
  task automatic t_updown();
    i_tct_pin_model.set_pin(0, 1'b0, 2);
    apb(1'b1, OFS_T2MODE, 8'h01);
    apb(1'b1, OFS_RCAPL, 8'h00);
    apb(1'b1, OFS_RCAPH, 8'h00);
    apb(1'b1, OFS_LOW2, 8'h02);
    apb(1'b1, OFS_HIGH2, 8'h00);
    apb(1'b1, OFS_T2CTRL, 8'h04);
    wait_irq(4, 200);
    apb(1'b0, OFS_T2CTRL, 8'h00);
    chk(rd, 32'hC4, "underflow flags");
    apb(1'b0, OFS_HIGH2, 8'h00);
    chk(rd, 32'hFF, "underflow load");
  endtask
  // ----------------------------------------------------------------------
  // Sequence and verdict
  // ----------------------------------------------------------------------
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    apb(1'b1, OFS_CLKCFG, 8'h01);
    t_t0(8'h00, 8'hFE, 8'hFF, 8'hE0, 8'h00);
    t_t0(8'h01, 8'hFE, 8'hFF, 8'h00, 8'h00);
    t_t0(8'h02, 8'hFF, 8'hF0, 8'hF0, 8'hF0);
    t_gate();
    t_split();
    t_capture();
    t_reload();
    t_updown();
    end_of_test();
  end
  // Watchdog against a hang
  initial begin
    #100us;
    failures++;
    end_of_test();
  end
endmodule

/* File: dv/tct_chk_sva.sv */
// Checker of bus handshake and timer flag behaviour
module tct_chk
  import tct_pkg::*;
(
  // Clock and reset
  input wire logic               pclk,
  input wire logic               presetn,
  // APB
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [7:0]         paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  // Pins, acknowledge, requests
  input wire tct_pkg::tct_pins_s pins,
  input wire tct_pkg::tct_ack_s  ack,
  input wire tct_pkg::tct_irq_s  irq
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------------
  // Transfer steps
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle
  sequence s_setup;
    psel && !penable;
  endsequence
  // First access cycle, answer not yet given
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_ONE_WAIT: assert property (s_setup ##1 s_wait |=> pready)
    else $error("pready not after one wait state");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("pready held too long");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  AST_UPPER_ZERO: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_UNMAPPED: assert property (psel && penable && !pready && !pwrite && paddr == 8'h34
    |=> pslverr && prdata == 32'h0) else $error("unmapped read not refused");
  AST_TF0_STICKY: assert property (irq.timer0 && !ack.timer0 &&
    !(psel && penable && pwrite && paddr == OFS_CTRL01) |=> irq.timer0)
    else $error("timer 0 flag dropped by itself");
  AST_T1_PULSE: assert property ($rose(irq.t1_ovf) |=> !irq.t1_ovf)
    else $error("timer 1 overflow pulse too long");
  AST_T2_PULSE: assert property (irq.t2_ovf |=> !irq.t2_ovf)
    else $error("third timer overflow pulse too long");
endmodule

bind tct_top tct_chk i_tct_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pins(pins), .ack(ack), .irq(irq));

/* File: dv/tct_pin_model.sv */
// Model of the external count, gate and trigger pins
module tct_pin_model
  import tct_pkg::*;
(
  // Clock
  input  wire logic          pclk,
  // Pins toward the block
  output tct_pkg::tct_pins_s pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle: every pin released high
  initial pins = 6'h3F;
  // Change one pin after an edge, then wait the given number of cycles
  task automatic set_pin(input int idx, input logic val, input int hold);
    logic [5:0] v;
    v = pins;
    v[idx] = val;
    @(posedge pclk);
    pins <= v;
    repeat (hold) @(posedge pclk);
  endtask
endmodule

/* File: hw/tct_pkg.sv */
// Shared constants, layouts and carrier types of the timer counter trio
package tct_pkg;

  // ----------------------------------------------------------------------
  // Register byte addresses on the APB
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL01   = 8'h00;  // timer01_control_reg
  localparam logic [7:0] OFS_MODE01   = 8'h04;  // timer01_mode_reg
  localparam logic [7:0] OFS_LOW0     = 8'h08;  // first_timer_low_byte
  localparam logic [7:0] OFS_HIGH0    = 8'h0C;  // first_timer_high_byte
  localparam logic [7:0] OFS_LOW1     = 8'h10;  // count_low_1
  localparam logic [7:0] OFS_HIGH1    = 8'h14;  // count_high_1
  localparam logic [7:0] OFS_T2CTRL   = 8'h18;  // third_timer_control
  localparam logic [7:0] OFS_T2MODE   = 8'h1C;  // third_timer_mode_reg
  localparam logic [7:0] OFS_LOW2     = 8'h20;  // third_timer_low_byte
  localparam logic [7:0] OFS_HIGH2    = 8'h24;  // third_timer_high_byte
  localparam logic [7:0] OFS_RCAPL    = 8'h28;  // reload_capture_low
  localparam logic [7:0] OFS_RCAPH    = 8'h2C;  // reload_capture_high
  localparam logic [7:0] OFS_CLKCFG   = 8'h30;  // Machine cycle length select

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int TC_TF1 = 7, TC_TR1 = 6, TC_TF0 = 5, TC_TR0 = 4;
  localparam int TC_IE1 = 3, TC_IT1 = 2, TC_IE0 = 1, TC_IT0 = 0;
  localparam int TM_GATE1 = 7, TM_CT1 = 6, TM_MODE1 = 4;
  localparam int TM_GATE0 = 3, TM_CT0 = 2, TM_MODE0 = 0;
  localparam int T2_TF2 = 7, T2_THIRD_TIMER_EXT_FLAG = 6, T2_RCLK = 5, T2_TCLK = 4;
  localparam int T2_THIRD_TIMER_EXT_ENABLE = 3, T2_TR2 = 2, T2_CT2 = 1, T2_CPRL2 = 0;
  localparam int T2M_DOWN_COUNT_ENABLE = 0;
  localparam logic [7:0] T2M_MASK   = 8'h03;  // Implemented mode bits
  localparam int CFG_SIX_CLK = 0;

  // ----------------------------------------------------------------------
  // Reset values, mode codes and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [15:0] RST_WORD   = 16'h0000;
  localparam logic [15:0] ALL_ONES16 = 16'hFFFF;
  localparam logic [1:0]  MODE_13BIT = 2'h0;
  localparam logic [1:0]  MODE_16BIT = 2'h1;
  localparam logic [1:0]  MODE_RELOAD8 = 2'h2;
  localparam logic [1:0]  MODE_SPLIT = 2'h3;
  localparam logic [3:0]  MC_CLOCKS_6  = 4'h6;  // Clocks per machine cycle
  localparam logic [3:0]  MC_CLOCKS_12 = 4'hC;

  // ----------------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic count_pin0;            // External count input, timer 0
    logic count_pin1;            // External count input, timer 1
    logic count_pin2;            // External count input, third timer
    logic ext_int_pin0_n;        // External interrupt / gate pin 0
    logic ext_int_pin1_n;        // External interrupt / gate pin 1
    logic third_timer_ext_input; // Trigger / direction input
  } tct_pins_s;

  typedef struct packed {
    logic timer0;  // Interrupt taken, clears first_timer_overflow
    logic timer1;  // Interrupt taken, clears second_timer_overflow
    logic ext0;    // Interrupt taken, clears first_ext_int_flag
    logic ext1;    // Interrupt taken, clears second_ext_int_flag
  } tct_ack_s;

  typedef struct packed {
    logic timer0;      // Timer 0 request level
    logic timer1;      // Timer 1 request level
    logic timer2;      // Third timer request level
    logic ext0;        // External interrupt 0 request level
    logic ext1;        // External interrupt 1 request level
    logic t1_ovf;      // One-cycle pulse per timer 1 overflow
    logic t2_ovf;      // One-cycle pulse per third timer overflow
  } tct_irq_s;

endpackage

/* File: hw/tct_top.sv */
// Three timer/counters with APB register access
//
// How it works
// - Mode 0: 13-bit count, wrap sets flag
// - Count only when run and gate allows
// - Low byte top bits kept; run keeps count
// - Separate gate bits: bit 7, bit 3
// - Mode 1: full 16-bit counter
// - Mode 2: 8-bit reload from high byte
// - Timer 1 mode 3 holds its count
// - Timer 0 mode 3: low byte own timer
// - Split high byte: machine cycles, timer 1 controls
// - Timer 1 free running while timer 0 split
// - Third timer counts ticks or pin edges
// - Capture mode overflow sets overflow flag
// - Capture on trigger fall sets external flag
// - Both third timer flags share one request
// - Capture mode never reloads count
// - Tick is clock over six or twelve
// - Reset clears down count; input picks direction
// - Up count to all ones then reload
// - Trigger fall also reloads, sets flag
// - Down mode, input high: count up, reload
// - Input low: count down, underflow loads ones
// - Up/down toggles external flag, no request
module tct_top
  import tct_pkg::*;
(
  // APB clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Device pins, asynchronous
  input  wire tct_pkg::tct_pins_s pins,
  // Interrupt acknowledge from the core, same clock
  input  wire tct_pkg::tct_ack_s  ack,
  // Interrupt requests and overflow pulses
  output tct_pkg::tct_irq_s       irq
);
  import tct_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    tct_pins_s   sync1;      // First synchroniser stage
    tct_pins_s   sync2;      // Second synchroniser stage
    tct_pins_s   last;       // Previous synchronised value
    logic [3:0]  presc;      // Machine cycle prescaler
    logic [7:0]  ctrl01;     // timer01_control_reg
    logic [7:0]  mode01;     // timer01_mode_reg
    logic [7:0]  low0;       // first_timer_low_byte
    logic [7:0]  high0;      // first_timer_high_byte
    logic [7:0]  low1;       // count_low_1
    logic [7:0]  high1;      // count_high_1
    logic [7:0]  t2ctrl;     // third_timer_control
    logic [7:0]  t2mode;     // third_timer_mode_reg
    logic [15:0] cnt2;       // Third timer high:low
    logic [15:0] rcap;       // reload_capture_high:low
    logic        six_clk;    // Six clocks per machine cycle
    logic [31:0] prdata;     // Read data
    logic        pready;     // Transfer completion
    logic        pslverr;    // Unmapped address
    tct_irq_s    irq;        // Registered requests
  } tct_state_s;

  tct_state_s state_reg;     // Current state
  tct_state_s state_next;    // Next state

  // Reset image: synchronisers start at the pins' idle high level so that
  // no false falling edge and no false low level follows reset
  localparam tct_state_s STATE_RST = '{sync1: '1, sync2: '1, last: '1, default: '0};

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // One count step of timer 0/1: returns {overflow, high, low}
  function automatic logic [16:0] step01(input logic [1:0] mode,
                                         input logic [7:0] hi,
                                         input logic [7:0] lo);
    logic [16:0] r;
    r = {1'b0, hi, lo};
    case (mode)
      MODE_13BIT: begin
        // High byte plus low five bits; top three bits left alone
        r[16] = ({hi, lo[4:0]} == ALL_ONES16[12:0]);
        {r[15:8], r[4:0]} = {hi, lo[4:0]} + 13'h0001;
      end
      MODE_16BIT: begin
        r[16] = ({hi, lo} == ALL_ONES16);
        r[15:0] = {hi, lo} + 16'h0001;
      end
      MODE_RELOAD8: begin
        // Low byte reloads from the untouched high byte
        r[16] = (lo == ALL_ONES16[7:0]);
        r[7:0] = r[16] ? hi : lo + 8'h01;
      end
      default: begin
        // Split low byte: plain 8-bit counter
        r[16] = (lo == ALL_ONES16[7:0]);
        r[7:0] = lo + 8'h01;
      end
    endcase
    return r;
  endfunction

  // Address is one of the mapped registers
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      OFS_CTRL01, OFS_MODE01, OFS_LOW0, OFS_HIGH0, OFS_LOW1, OFS_HIGH1,
      OFS_T2CTRL, OFS_T2MODE, OFS_LOW2, OFS_HIGH2, OFS_RCAPL, OFS_RCAPH,
      OFS_CLKCFG: mapped = 1'b1;
      default:    mapped = 1'b0;
    endcase
  endfunction

  // Read view of a register, unused bits zero
  function automatic logic [7:0] rd_byte(input tct_state_s s, input logic [7:0] a);
    case (a)
      OFS_CTRL01: rd_byte = s.ctrl01;
      OFS_MODE01: rd_byte = s.mode01;
      OFS_LOW0:   rd_byte = s.low0;
      OFS_HIGH0:  rd_byte = s.high0;
      OFS_LOW1:   rd_byte = s.low1;
      OFS_HIGH1:  rd_byte = s.high1;
      OFS_T2CTRL: rd_byte = s.t2ctrl;
      OFS_T2MODE: rd_byte = s.t2mode;
      OFS_LOW2:   rd_byte = s.cnt2[7:0];
      OFS_HIGH2:  rd_byte = s.cnt2[15:8];
      OFS_RCAPL:  rd_byte = s.rcap[7:0];
      OFS_RCAPH:  rd_byte = s.rcap[15:8];
      OFS_CLKCFG: rd_byte = {7'h00, s.six_clk};
      default:    rd_byte = RST_BYTE;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    tct_state_s n;
    tct_pins_s  fall;       // Falling edges of synchronised pins
    logic       tick;       // Machine cycle strobe
    logic [1:0] mode0;      // Timer 0 mode
    logic [1:0] mode1;      // Timer 1 mode
    logic       split;      // Timer 0 split in two
    logic       en0;        // Timer 0 count enable
    logic       en1;        // Timer 1 count enable
    logic       en2;        // Third timer count enable
    logic [16:0] r0;        // Timer 0 step result
    logic [16:0] r1;        // Timer 1 step result
    logic       set_tf0;    // Hardware sets of the flags
    logic       set_tf1;
    logic       set_ie0;
    logic       set_ie1;
    logic       set_tf2;
    logic       set_third_timer_ext_flag;
    logic       tog_third_timer_ext_flag;
    logic       baud;       // Third timer in baud clock mode
    logic       capture;    // Third timer in capture mode
    logic       updown;     // Third timer direction from pin
    logic       ex_edge;    // Qualified trigger falling edge
    logic       access;     // APB access phase
    logic       wr_fire;    // Write completes this edge
    logic [7:0] wb;         // Write byte

    n = state_reg;
    fall = tct_pins_s'(state_reg.last & ~state_reg.sync2);
    set_tf0 = 1'b0;
    set_tf1 = 1'b0;
    set_tf2 = 1'b0;
    set_third_timer_ext_flag = 1'b0;
    tog_third_timer_ext_flag = 1'b0;
    r0 = 17'h00000;
    r1 = 17'h00000;

    // Pin synchronisers and edge history
    n.sync1 = pins;
    n.sync2 = state_reg.sync1;
    n.last = state_reg.sync2;

    // Machine cycle prescaler
    tick = (state_reg.presc == (state_reg.six_clk ? MC_CLOCKS_6 : MC_CLOCKS_12) - 4'h1);
    n.presc = tick ? 4'h0 : state_reg.presc + 4'h1;

    // Timer 0 and timer 1 modes
    mode0 = state_reg.mode01[TM_MODE0 +: 2];
    mode1 = state_reg.mode01[TM_MODE1 +: 2];
    split = (mode0 == MODE_SPLIT);

    // Timer 0 (or its low byte when split)
    en0 = state_reg.ctrl01[TC_TR0]
          && (!state_reg.mode01[TM_GATE0] || state_reg.sync2.ext_int_pin0_n)
          && (state_reg.mode01[TM_CT0] ? fall.count_pin0 : tick);
    if (en0) begin
      r0 = step01(mode0, state_reg.high0, state_reg.low0);
      n.low0 = r0[7:0];
      if (!split) begin
        n.high0 = r0[15:8];
      end
      set_tf0 = r0[16];
    end

    // Split high byte: machine cycles under timer 1 run bit
    if (split && state_reg.ctrl01[TC_TR1] && tick) begin
      n.high0 = state_reg.high0 + 8'h01;
      set_tf1 = (state_reg.high0 == ALL_ONES16[7:0]);
    end

    // Timer 1: held in its mode 3, free running while timer 0 is split
    en1 = (split || state_reg.ctrl01[TC_TR1])
          && (mode1 != MODE_SPLIT)
          && (!state_reg.mode01[TM_GATE1] || state_reg.sync2.ext_int_pin1_n)
          && (state_reg.mode01[TM_CT1] ? fall.count_pin1 : tick);
    n.irq.t1_ovf = 1'b0;
    if (en1) begin
      r1 = step01(mode1, state_reg.high1, state_reg.low1);
      n.low1 = r1[7:0];
      n.high1 = r1[15:8];
      n.irq.t1_ovf = r1[16];
      if (!split) begin
        set_tf1 = r1[16];
      end
    end

    // External interrupt flags: falling edge or low level
    set_ie0 = state_reg.ctrl01[TC_IT0] ? fall.ext_int_pin0_n : !state_reg.sync2.ext_int_pin0_n;
    set_ie1 = state_reg.ctrl01[TC_IT1] ? fall.ext_int_pin1_n : !state_reg.sync2.ext_int_pin1_n;

    // Third timer mode decode
    baud = state_reg.t2ctrl[T2_RCLK] || state_reg.t2ctrl[T2_TCLK];
    capture = state_reg.t2ctrl[T2_CPRL2] && !baud;
    updown = state_reg.t2mode[T2M_DOWN_COUNT_ENABLE] && !capture && !baud;
    ex_edge = state_reg.t2ctrl[T2_THIRD_TIMER_EXT_ENABLE] && fall.third_timer_ext_input;
    en2 = state_reg.t2ctrl[T2_TR2]
          && (state_reg.t2ctrl[T2_CT2] ? fall.count_pin2 : tick);
    n.irq.t2_ovf = 1'b0;

    // Third timer counting
    if (en2) begin
      if (updown && !state_reg.sync2.third_timer_ext_input) begin
        // Down count: underflow at the reload value
        if (state_reg.cnt2 == state_reg.rcap) begin
          n.cnt2 = ALL_ONES16;
          set_tf2 = 1'b1;
          tog_third_timer_ext_flag = 1'b1;
          n.irq.t2_ovf = 1'b1;
        end else begin
          n.cnt2 = state_reg.cnt2 - 16'h0001;
        end
      end else if (state_reg.cnt2 == ALL_ONES16) begin
        // Up count overflow
        n.irq.t2_ovf = 1'b1;
        if (capture) begin
          n.cnt2 = RST_WORD;
          set_tf2 = 1'b1;
        end else begin
          n.cnt2 = state_reg.rcap;
          set_tf2 = !baud;
          tog_third_timer_ext_flag = updown;
        end
      end else begin
        n.cnt2 = state_reg.cnt2 + 16'h0001;
      end
    end

    // Trigger falling edge: capture, reload or flag only
    if (ex_edge && !updown) begin
      set_third_timer_ext_flag = 1'b1;
      if (capture) begin
        n.rcap = state_reg.cnt2;
      end else if (!baud) begin
        n.cnt2 = state_reg.rcap;
      end
    end

    // Interrupt acknowledge clears the flags
    if (ack.timer0) begin
      n.ctrl01[TC_TF0] = 1'b0;
    end
    if (ack.timer1) begin
      n.ctrl01[TC_TF1] = 1'b0;
    end
    if (ack.ext0) begin
      n.ctrl01[TC_IE0] = 1'b0;
    end
    if (ack.ext1) begin
      n.ctrl01[TC_IE1] = 1'b0;
    end

    // APB slave: answer one cycle into the access phase
    access = psel && penable;
    wr_fire = access && pwrite && state_reg.pready;
    wb = pwdata[7:0];
    n.pready = access && !state_reg.pready;
    n.pslverr = access && !state_reg.pready && !mapped(paddr);
    if (access && !state_reg.pready) begin
      n.prdata = (pwrite || !mapped(paddr)) ? 32'h0000_0000
                 : {24'h000000, rd_byte(state_reg, paddr)};
    end

    // Software writes; count registers are not cleared by run bits
    if (wr_fire) begin
      case (paddr)
        OFS_CTRL01: n.ctrl01 = wb;
        OFS_MODE01: n.mode01 = wb;
        OFS_LOW0:   n.low0 = wb;
        OFS_HIGH0:  n.high0 = wb;
        OFS_LOW1:   n.low1 = wb;
        OFS_HIGH1:  n.high1 = wb;
        OFS_T2CTRL: n.t2ctrl = wb;
        OFS_T2MODE: n.t2mode = wb & T2M_MASK;
        OFS_LOW2:   n.cnt2[7:0] = wb;
        OFS_HIGH2:  n.cnt2[15:8] = wb;
        OFS_RCAPL:  n.rcap[7:0] = wb;
        OFS_RCAPH:  n.rcap[15:8] = wb;
        OFS_CLKCFG: n.six_clk = wb[CFG_SIX_CLK];
        default:    n.prdata = n.prdata;
      endcase
    end

    // Hardware sets win over any clear in the same cycle
    n.ctrl01[TC_TF0] = n.ctrl01[TC_TF0] | set_tf0;
    n.ctrl01[TC_TF1] = n.ctrl01[TC_TF1] | set_tf1;
    n.ctrl01[TC_IE0] = n.ctrl01[TC_IE0] | set_ie0;
    n.ctrl01[TC_IE1] = n.ctrl01[TC_IE1] | set_ie1;
    n.t2ctrl[T2_TF2] = n.t2ctrl[T2_TF2] | set_tf2;
    n.t2ctrl[T2_THIRD_TIMER_EXT_FLAG] = (n.t2ctrl[T2_THIRD_TIMER_EXT_FLAG] ^ tog_third_timer_ext_flag) | set_third_timer_ext_flag;

    // Registered request levels
    n.irq.timer0 = n.ctrl01[TC_TF0];
    n.irq.timer1 = n.ctrl01[TC_TF1];
    n.irq.ext0 = n.ctrl01[TC_IE0];
    n.irq.ext1 = n.ctrl01[TC_IE1];
    n.irq.timer2 = n.t2ctrl[T2_TF2]
                   | (n.t2ctrl[T2_THIRD_TIMER_EXT_FLAG] & !(n.t2mode[T2M_DOWN_COUNT_ENABLE] & !n.t2ctrl[T2_CPRL2]
                      & !n.t2ctrl[T2_RCLK] & !n.t2ctrl[T2_TCLK]));

    state_next = n;
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------------
  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign irq = state_reg.irq;

endmodule
